// >>> verilog/usb_irq_enable_error_status.sv
// interrupt enable and error status registers with gated interrupt request
//
// Local design decisions: the plain strobed port and the placing of the registers.
`include "usb_irq_map.svh"
// register index map, low byte carries every implemented bit:
//   0  interrupt enable, read and write
//   1  error flags, hardware set, write one to clear
//   2  error interrupt status, event sets, read clears, set wins
//   3  error mask, gates both the summary and the error interrupt
//   4  gated interrupt status, read only snapshot
//   5  control, bit zero selects host operation
// unmapped indexes read zero and ignore writes.
// hazards:
//   a flag event and a clear in one cycle leave the flag set,
//   so software never loses an error it has not yet seen.
//   the attach source is held off in device operation.
module usb_irq_enable_error_status #(
  parameter int unsigned IMPL_W = `IRQ_IMPL_W
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire usb_irq_pkg::reg_addr_t addr,
  input  wire usb_irq_pkg::reg_word_t wdata,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  output usb_irq_pkg::reg_word_t      rdata,
  input  wire usb_irq_pkg::flag_byte_t status_flags,
  input  wire logic                   bus_reset_flag,
  input  wire logic                   bit_stuff_error,
  input  wire usb_irq_pkg::flag_byte_t error_events,
  output logic                        module_irq,
  output logic                        error_summary,
  output logic                        error_irq
);
  import usb_irq_pkg::*;

  // elaboration check: the register map serves an eight bit low byte only
  if (IMPL_W != 8) begin : g_bad_width
    $error("IMPL_W must be 8");
  end

  reg_word_t  rdata_q;
  logic       irq_q;
  logic       errsum_q;
  logic       errirq_q;
  flag_byte_t enable_q;
  flag_byte_t errmask_q;
  flag_byte_t errstat_q;
  logic       host_mode_q;
  flag_byte_t err_flags;
  flag_byte_t err_set;
  flag_byte_t err_clr;
  // per bit source selection and gating, driven bit by bit
  wire flag_byte_t stat_gated;
  wire flag_byte_t src_eff;
  // next values of the registered outputs and sticky status
  flag_byte_t errstat_keep;
  flag_byte_t errstat_d;
  logic       errirq_d;
  reg_word_t  rdata_d;
  logic       wr_enable;
  logic       wr_errflags;
  logic       wr_errmask;
  logic       wr_ctrl;
  logic       rd_errstat;
  logic       summary;

  // address decode of single cycle strobes
  assign wr_enable   = wr_en && (addr == `IRQ_OFS_ENABLE);
  assign wr_errflags = wr_en && (addr == `IRQ_OFS_ERRFLAGS);
  assign wr_errmask  = wr_en && (addr == `IRQ_OFS_ERRMASK);
  assign wr_ctrl     = wr_en && (addr == `IRQ_OFS_CONTROL);
  assign rd_errstat  = rd_en && (addr == `IRQ_OFS_ERRSTATUS);

  // enable register, low byte only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_q <= `IRQ_ENABLE_RESET;
    end else if (wr_enable) begin
      enable_q <= wdata[7:0];
    end
  end

  // host or device operation select
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_mode_q <= `IRQ_HOST_RESET;
    end else if (wr_ctrl) begin
      host_mode_q <= wdata[`IRQ_CTRL_HOST];
    end
  end

  // error flag bank events: bit stuff input folded into bit seven
  always_comb begin
    err_set = error_events;
    err_set[`IRQ_BIT_BITSTUFF] = error_events[`IRQ_BIT_BITSTUFF] | bit_stuff_error;
    err_clr = wr_errflags ? wdata[7:0] : 8'h00;
  end

  error_flag_bank #(
    .WIDTH (IMPL_W),
    .IMPL  (`IRQ_ERRFLAG_IMPL)
  ) u_flags (
    .clk       (clk),
    .rstn      (rstn),
    .set_pulse (err_set),
    .clr_mask  (err_clr),
    .flags_q   (err_flags)
  );

  // error summary mask register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      errmask_q <= `IRQ_ERRMASK_RESET;
    end else if (wr_errmask) begin
      errmask_q <= wdata[7:0];
    end
  end

  assign summary = |(err_flags & errmask_q);

  // effective source per bit: bit zero is bus reset in device, detach in host;
  // the attach source only counts in host operation, so a line change seen
  // while acting as device never wakes software
  for (genvar b = 0; b < 8; b++) begin : g_src
    if (b == `IRQ_BIT_RSTDET) begin : g_rstdet
      assign src_eff[b] = host_mode_q ? status_flags[b] : bus_reset_flag;
    end else if (b == `IRQ_BIT_ATTACH) begin : g_attach
      assign src_eff[b] = status_flags[b] & host_mode_q;
    end else begin : g_plain
      assign src_eff[b] = status_flags[b];
    end
    // each enable bit passes or masks only its own source
    assign stat_gated[b] = src_eff[b] & enable_q[b];
  end

  // module interrupt request, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_q    <= 1'b0;
      errsum_q <= 1'b0;
    end else begin
      irq_q    <= |stat_gated;
      errsum_q <= summary;
    end
  end

  // sticky error status next value: a read clears, an event in the same
  // cycle still sets, so no event slips between read and clear
  always_comb begin
    errstat_keep = rd_errstat ? 8'h00 : errstat_q;
    errstat_d    = errstat_keep | (err_set & `IRQ_ERRFLAG_IMPL);
    errirq_d     = |(errstat_d & errmask_q); // level while an unmasked bit stands
  end

  // sticky error interrupt status register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      errstat_q <= `IRQ_ERRSTAT_RESET;
    end else begin
      errstat_q <= errstat_d;
    end
  end

  // error interrupt request, registered so the pin never glitches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      errirq_q <= 1'b0;
    end else begin
      errirq_q <= errirq_d;
    end
  end

  // read multiplexer: upper byte always zero, unmapped indexes read zero;
  // the bus stays at zero outside a read so idle cycles carry no stale data
  always_comb begin
    rdata_d = `IRQ_RDATA_RESET;
    if (rd_en) begin
      unique case (addr)
        `IRQ_OFS_ENABLE:    rdata_d = {8'h00, enable_q};
        `IRQ_OFS_ERRFLAGS:  rdata_d = {8'h00, err_flags};
        `IRQ_OFS_ERRSTATUS: rdata_d = {8'h00, errstat_q};
        `IRQ_OFS_ERRMASK:   rdata_d = {8'h00, errmask_q};
        `IRQ_OFS_STATUS:    rdata_d = {8'h00, stat_gated};
        `IRQ_OFS_CONTROL:   rdata_d = {15'h0000, host_mode_q};
        default:            rdata_d = `IRQ_RDATA_RESET;
      endcase
    end
  end

  // read data register, valid the cycle after the read strobe only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= `IRQ_RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // every output comes straight from its register

  assign rdata         = rdata_q;
  assign module_irq    = irq_q;
  assign error_summary = errsum_q;
  assign error_irq     = errirq_q;
endmodule

// >>> verilog/usb_irq_map.svh
// register offsets, field positions, reset values and widths for the interrupt enable block
`ifndef USB_IRQ_MAP_SVH
`define USB_IRQ_MAP_SVH

`define IRQ_ADDR_W         4
`define IRQ_OFS_ENABLE     4'h0
`define IRQ_OFS_ERRFLAGS   4'h1
`define IRQ_OFS_ERRSTATUS  4'h2
`define IRQ_OFS_ERRMASK    4'h3
`define IRQ_OFS_STATUS     4'h4
`define IRQ_OFS_CONTROL    4'h5

`define IRQ_ENABLE_RESET   8'h00
`define IRQ_ERRMASK_RESET  8'h00
`define IRQ_ERRSTAT_RESET  8'h00
`define IRQ_HOST_RESET     1'b0
`define IRQ_RDATA_RESET    16'h0000
`define IRQ_ERRFLAG_RESET  8'h00
`define IRQ_ERRFLAG_IMPL   8'hbf
`define IRQ_BIT_ATTACH     6
`define IRQ_BIT_BITSTUFF   7
`define IRQ_BIT_RSTDET     0
`define IRQ_CTRL_HOST      0
`define IRQ_DATA_W         16
`define IRQ_IMPL_W         8

`endif

// >>> verilog/usb_irq_pkg.sv
// types shared by the interrupt enable block
package usb_irq_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [3:0]  reg_addr_t;
  typedef logic [7:0]  flag_byte_t;
endpackage

// >>> verilog/error_flag_bank.sv
// bank of sticky error flags: hardware sets, write one to clear, set wins
`include "usb_irq_map.svh"
module error_flag_bank #(
  parameter int unsigned           WIDTH = 8,
  parameter logic [WIDTH-1:0]      IMPL  = `IRQ_ERRFLAG_IMPL
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] set_pulse,
  input  wire logic [WIDTH-1:0] clr_mask,
  output wire logic [WIDTH-1:0] flags_q
);
  logic flag_bit_q [WIDTH];

  // elaboration check: an empty bank cannot hold any flag
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  // one flag per bit; unimplemented positions stay zero
  for (genvar i = 0; i < WIDTH; i++) begin : g_flag
    if (IMPL[i]) begin : g_impl
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          flag_bit_q[i] <= 1'b0;
        end else if (set_pulse[i]) begin
          flag_bit_q[i] <= 1'b1;
        end else if (clr_mask[i]) begin
          flag_bit_q[i] <= 1'b0;
        end
      end
    end else begin : g_none
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          flag_bit_q[i] <= 1'b0;
        end else begin
          flag_bit_q[i] <= 1'b0;
        end
      end
    end
    assign flags_q[i] = flag_bit_q[i];
  end
endmodule

// >>> verif/usb_irq_sva.sv
// port assertions for the interrupt enable block
module usb_irq_sva (
  input wire logic                    clk,
  input wire logic                    rstn,
  input wire usb_irq_pkg::reg_addr_t  addr,
  input wire usb_irq_pkg::reg_word_t  wdata,
  input wire logic                    wr_en,
  input wire logic                    rd_en,
  input wire usb_irq_pkg::reg_word_t  rdata,
  input wire usb_irq_pkg::flag_byte_t status_flags,
  input wire logic                    bus_reset_flag,
  input wire logic                    bit_stuff_error,
  input wire usb_irq_pkg::flag_byte_t error_events,
  input wire logic                    module_irq,
  input wire logic                    error_summary,
  input wire logic                    error_irq
);
  import usb_irq_pkg::*;
  flag_byte_t en_q, mk_q, src;
  logic       host_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // shadow copies of enable, mask and mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_q   <= 8'h00;
      mk_q   <= 8'h00;
      host_q <= 1'b0;
    end else if (wr_en) begin
      if (addr == 4'h0) en_q <= wdata[7:0];
      if (addr == 4'h3) mk_q <= wdata[7:0];
      if (addr == 4'h5) host_q <= wdata[0];
    end
  end
  // attach counts in host only, bit zero follows mode
  assign src = {status_flags[7], status_flags[6] & host_q, status_flags[5:1],
                host_q ? status_flags[0] : bus_reset_flag};
  sequence s_stuff_rd;
    bit_stuff_error ##1 (rd_en && addr == 4'h1);
  endsequence
  sequence s_clr_rd;
    (wr_en && addr == 4'h1 && wdata[0] && !error_events[0]) ##1 !error_events[0]
      ##1 (rd_en && addr == 4'h1);
  endsequence
  a_rdata_idle_zero: assert property (!$past(rd_en) |-> rdata == 16'h0000)
    else $error("rdata outside read");
  a_upper_byte_zero: assert property (rdata[15:8] == 8'h00)
    else $error("upper byte set");
  a_enable_read_back: assert property (rd_en && addr == 4'h0 |=> rdata == {8'h00, en_q})
    else $error("enable readback");
  a_irq_gated_src: assert property (module_irq == $past(|(src & en_q)))
    else $error("irq gating");
  a_stuff_sets_flag: assert property (s_stuff_rd |=> rdata[7])
    else $error("stuff flag");
  a_flag_six_zero: assert property (rd_en && addr == 4'h1 |=> !rdata[6])
    else $error("flag bit six");
  a_one_clears_flag: assert property (s_clr_rd |=> !rdata[0])
    else $error("flag not cleared");
  a_summary_needs_mask: assert property (error_summary |-> $past(mk_q) != 8'h00)
    else $error("summary unmasked");
endmodule

// >>> verif/usb_irq_enable_error_status_tb_top.sv
// self-checking bench for the interrupt enable block
module usb_irq_enable_error_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import usb_irq_pkg::*;
  logic       clk = 0, rstn = 0, wr_en = 0, rd_en = 0, bus_reset_flag = 0, bit_stuff_error = 0;
  logic       module_irq, error_summary, error_irq;
  reg_addr_t  addr = 4'h0;
  reg_word_t  wdata = 16'h0000, rdata;
  flag_byte_t status_flags = 8'h00, error_events = 8'h00;
  int         err_total = 0, cmp_count = 0;
  initial forever #50 clk = ~clk;
  usb_irq_enable_error_status i_usb_irq_enable_error_status (.clk, .rstn, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .status_flags, .bus_reset_flag, .bit_stuff_error,
    .error_events, .module_irq, .error_summary, .error_irq);
  task chk(string n, reg_word_t s, reg_word_t e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  // one write strobe, then an idle cycle
  task wr(reg_addr_t a, reg_word_t d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  // read strobe, data checked mid-cycle after it
  task rd(reg_addr_t a, reg_word_t e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk("rdata", rdata, e);
    @(posedge clk);
  endtask
  task irq(logic e);
    @(posedge clk);
    @(negedge clk);
    chk("module_irq", {15'h0000, module_irq}, {15'h0000, e});
    @(posedge clk);
  endtask
  task pulse(flag_byte_t e, logic b);
    error_events <= e;
    bit_stuff_error <= b;
    @(posedge clk);
    error_events <= 8'h00;
    bit_stuff_error <= 1'b0;
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog of 1000 cycles, well beyond the 60 or so cycles the tests need
  initial begin
    #100000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    rd(4'h9, 16'h0000);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h00ff);
    $display("registers done");
    status_flags <= 8'h40;
    irq(1'b0);
    wr(4'h5, 16'h0001);
    irq(1'b1);
    wr(4'h0, 16'h00bf);
    irq(1'b0);
    status_flags <= 8'h01;
    irq(1'b1);
    status_flags <= 8'h00;
    bus_reset_flag <= 1'b1;
    irq(1'b0);
    wr(4'h5, 16'h0000);
    irq(1'b1);
    rd(4'h5, 16'h0000);
    rd(4'h4, 16'h0001);
    $display("gating done");
    wr(4'h3, 16'h0001);
    rd(4'h3, 16'h0001);
    pulse(8'hff, 1'b0);
    rd(4'h1, 16'h00bf);
    chk("error_irq", {15'h0000, error_irq}, 16'h0001);
    chk("error_summary", {15'h0000, error_summary}, 16'h0001);
    wr(4'h1, 16'hff81);
    rd(4'h1, 16'h003e);
    chk("error_summary", {15'h0000, error_summary}, 16'h0000);
    pulse(8'h00, 1'b1);
    rd(4'h1, 16'h00be);
    rd(4'h2, 16'h00bf);
    chk("error_irq", {15'h0000, error_irq}, 16'h0000);
    rd(4'h2, 16'h0000);
    $display("error flags done");
    tally_and_finish;
  end
endmodule
bind usb_irq_enable_error_status usb_irq_sva i_usb_irq_sva (.clk, .rstn, .addr, .wdata,
  .wr_en, .rd_en, .rdata, .status_flags, .bus_reset_flag, .bit_stuff_error,
  .error_events, .module_irq, .error_summary, .error_irq);
